//--- include/cbic_params.svh
`ifndef CBIC_PARAMS_SVH
`define CBIC_PARAMS_SVH
// Summary of operation
// - slave at 100kHz and 400kHz bus rates
// - address 110110 plus address pin bit
// - first write byte loads register pointer
// - pointer steps per byte, msb first
// - transfers may end after any byte
// - each byte written to 0-9 or C-F stored at once
// - switchover style forced or glitch-free
// - routing source: pin or register code
// - routing code picks input per divider
// - hold resets dividers, release aligns them
// - quiet disable tristates whole bank
// - bank power-off powers bank down
// - keep quiet disable set during power-up
// - divider power-off; bypass needs ratio zero
// - supply hint stored, 1 means low supply
// - write zero to reserved bits
// - register space decode 0 to F

// slave address and register map
`define CBIC_ADDR_STEM 6'h36
`define CBIC_REG_ROUTE 8'h00
`define CBIC_REG_BANK 8'h01
`define CBIC_RSVD_LO 8'h0A
`define CBIC_RSVD_HI 8'h0B
`define CBIC_REG_LAST 8'h0F
`define CBIC_ROUTE_MASK 8'hF1
`define CBIC_ROUTE_RST 8'h00
`define CBIC_BANK_RST 8'h00
// routing register fields
`define CBIC_F_STYLE 7
`define CBIC_F_CODE_HI 6
`define CBIC_F_CODE_LO 5
`define CBIC_F_SRC 4
`define CBIC_F_HOLD 0
// bank register fields
`define CBIC_F_SUP_A 7
`define CBIC_F_SUP_B 6
`define CBIC_F_QD_A 5
`define CBIC_F_QD_B 4
`define CBIC_F_PWR_A 3
`define CBIC_F_PWR_B 2
`define CBIC_F_DIV_A 1
`define CBIC_F_DIV_B 0
// controller avalon map
`define CBIC_AV_CTRL 4'h0
`define CBIC_AV_STAT 4'h4
`define CBIC_AV_TX 4'h8
`define CBIC_AV_RX 4'hC
`define CBIC_C_GO 0
`define CBIC_C_RD 1
`define CBIC_C_PTR_EN 2
`define CBIC_C_FAST 3
`define CBIC_C_ABIT 4
`define CBIC_C_CNT 8
`define CBIC_C_PTR 16
`define CBIC_S_BUSY 0
`define CBIC_S_NACK 1
// timing
`define CBIC_SYS_CLK_NS 25
`define CBIC_STD_PERIOD_NS 10000
`define CBIC_FAST_PERIOD_NS 2500
`define CBIC_STD_QCYC ((`CBIC_STD_PERIOD_NS + 4 * `CBIC_SYS_CLK_NS - 1) / (4 * `CBIC_SYS_CLK_NS))
`define CBIC_FAST_QCYC ((`CBIC_FAST_PERIOD_NS + 4 * `CBIC_SYS_CLK_NS - 1) / (4 * `CBIC_SYS_CLK_NS))
`endif

//--- include/cbic_pkg.sv
`default_nettype none
package cbic_pkg;
   typedef enum logic {SRC_ZERO = 1'b0, SRC_ONE = 1'b1} cbic_src_t;
   typedef enum logic [3:0] {
      S_IDLE = 4'h0, S_ADDR = 4'h1, S_ADDR_ACK = 4'h2, S_PTR = 4'h3, S_PTR_ACK = 4'h4,
      S_WDATA = 4'h5, S_WACK = 4'h6, S_RDATA = 4'h7, S_RACK = 4'h8
   } cbic_slave_state_t;
   typedef enum logic [1:0] {
      M_IDLE = 2'h0, M_START = 2'h1, M_BIT = 2'h2, M_STOP = 2'h3
   } cbic_bit_state_t;
   typedef enum logic [2:0] {
      B_ADDRW = 3'h0, B_PTR = 3'h1, B_DATA = 3'h2, B_ADDRR = 3'h3, B_RDATA = 3'h4
   } cbic_stage_t;
endpackage
`default_nettype wire

//--- include/cbic_i2c_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cbic_i2c_if;
   logic ctrl_scl_o;
   logic ctrl_scl_oe;
   logic ctrl_sda_o;
   logic ctrl_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;
   // open-drain wire with pull-up; device never stretches the clock
   assign scl = ctrl_scl_oe ? ctrl_scl_o : 1'b1;
   assign sda = (ctrl_sda_oe ? ctrl_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);
   modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
   modport controller (input scl, input sda, output ctrl_scl_o, output ctrl_scl_oe,
                       output ctrl_sda_o, output ctrl_sda_oe);
endinterface
`default_nettype wire

//--- logic/cbic_i2c_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbic_params.svh"
module cbic_i2c_device (
   // system
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // serial link
   cbic_i2c_if.device link,
   // pins
   input wire logic addr_bit_chipsel_pin_i,
   input wire logic ref_select_pin_i,
   // reference routing
   output var cbic_pkg::cbic_src_t div_a_source_o,
   output var cbic_pkg::cbic_src_t div_b_source_o,
   output logic switchover_style_o,
   output logic divider_hold_o,
   output logic divider_align_o,
   // bank control
   output logic bank_a_supply_hint_o,
   output logic bank_b_supply_hint_o,
   output logic bank_a_quiet_disable_o,
   output logic bank_b_quiet_disable_o,
   output logic bank_a_power_off_o,
   output logic bank_b_power_off_o,
   output logic divider_a_power_off_o,
   output logic divider_b_power_off_o
);
   import cbic_pkg::*;

   cbic_slave_state_t state;
   logic scl_q;
   logic sda_q;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic [7:0] ptr;
   logic rw;
   logic sda_oe;
   logic [7:0] route_reg;
   logic [7:0] bank_reg;
   logic [7:0] reg_mem [0:15];
   logic [7:0] rd_byte;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic addr_match;
   logic wr_now;

   assign link.dev_sda_o = 1'b0;
   assign link.dev_sda_oe = sda_oe;

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= link.scl;
         sda_q <= link.sda;
      end
   end

   assign scl_rise = link.scl & ~scl_q;
   assign scl_fall = ~link.scl & scl_q;
   // sda may only move while scl is low, so a change under high scl is a frame mark
   assign start_seen = scl_q & link.scl & sda_q & ~link.sda;
   assign stop_seen = scl_q & link.scl & ~sda_q & link.sda;
   assign addr_match = (shift[7:1] == {`CBIC_ADDR_STEM, addr_bit_chipsel_pin_i});
   assign wr_now = (state == S_WDATA) && scl_fall && (bit_cnt == 4'h8);

   // reserved and unmapped offsets read as zero
   always_comb
   begin
      rd_byte = 8'h00;
      if (ptr == `CBIC_REG_ROUTE)
         rd_byte = route_reg & `CBIC_ROUTE_MASK;
      else if (ptr == `CBIC_REG_BANK)
         rd_byte = bank_reg;
      else if (ptr <= `CBIC_REG_LAST && ptr != `CBIC_RSVD_LO && ptr != `CBIC_RSVD_HI)
         rd_byte = reg_mem[ptr[3:0]];
   end

   // byte-level slave sequencer
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         state <= S_IDLE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         rw <= 1'b0;
         sda_oe <= 1'b0;
      end
      else if (stop_seen)
      begin
         state <= S_IDLE;
         sda_oe <= 1'b0;
      end
      else if (start_seen)
      begin
         state <= S_ADDR;
         bit_cnt <= 4'h0;
         sda_oe <= 1'b0;
      end
      else if (scl_rise)
      begin
         case (state)
            S_ADDR, S_PTR, S_WDATA:
            begin
               shift <= {shift[6:0], link.sda};
               bit_cnt <= bit_cnt + 4'h1;
            end
            S_RDATA:
               bit_cnt <= bit_cnt + 4'h1;
            S_RACK:
               if (link.sda)
                  state <= S_IDLE;
            default:
               ;
         endcase
      end
      else if (scl_fall)
      begin
         case (state)
            S_ADDR:
               if (bit_cnt == 4'h8)
               begin
                  if (addr_match)
                  begin
                     state <= S_ADDR_ACK;
                     sda_oe <= 1'b1;
                     rw <= shift[0];
                  end
                  else
                     state <= S_IDLE;
               end
            S_ADDR_ACK:
            begin
               bit_cnt <= 4'h0;
               if (rw)
               begin
                  state <= S_RDATA;
                  shift <= rd_byte;
                  sda_oe <= ~rd_byte[7];
               end
               else
               begin
                  state <= S_PTR;
                  sda_oe <= 1'b0;
               end
            end
            S_PTR:
               if (bit_cnt == 4'h8)
               begin
                  state <= S_PTR_ACK;
                  sda_oe <= 1'b1;
               end
            S_WDATA:
               if (bit_cnt == 4'h8)
               begin
                  state <= S_WACK;
                  sda_oe <= 1'b1;
               end
            S_PTR_ACK, S_WACK:
            begin
               state <= S_WDATA;
               sda_oe <= 1'b0;
               bit_cnt <= 4'h0;
            end
            S_RDATA:
               if (bit_cnt == 4'h8)
               begin
                  state <= S_RACK;
                  sda_oe <= 1'b0;
               end
               else
               begin
                  shift <= {shift[6:0], 1'b0};
                  sda_oe <= ~shift[6];
               end
            S_RACK:
            begin
               state <= S_RDATA;
               shift <= rd_byte;
               sda_oe <= ~rd_byte[7];
               bit_cnt <= 4'h0;
            end
            default:
               state <= S_IDLE;
         endcase
      end
   end

   // pointer survives stop and repeated start
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         ptr <= 8'h00;
      else if (!start_seen && !stop_seen && scl_fall)
      begin
         if (state == S_PTR && bit_cnt == 4'h8)
            ptr <= shift;
         else if ((state == S_WDATA || state == S_RDATA) && bit_cnt == 4'h8)
            ptr <= ptr + 8'h01;
      end
   end

   // register file; bank and ratio bytes are kept for the output stage
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         route_reg <= `CBIC_ROUTE_RST;
         bank_reg <= `CBIC_BANK_RST;
         for (int i = 0; i < 16; i++)
            reg_mem[i] <= 8'h00;
      end
      else if (wr_now && !start_seen && !stop_seen)
      begin
         if (ptr == `CBIC_REG_ROUTE)
            route_reg <= shift & `CBIC_ROUTE_MASK;
         else if (ptr == `CBIC_REG_BANK)
            bank_reg <= shift;
         else if (ptr <= `CBIC_REG_LAST && ptr != `CBIC_RSVD_LO && ptr != `CBIC_RSVD_HI)
            reg_mem[ptr[3:0]] <= shift;
      end
   end

   // reference routing to the two bank dividers
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         div_a_source_o <= SRC_ZERO;
         div_b_source_o <= SRC_ZERO;
         switchover_style_o <= 1'b0;
      end
      else
      begin
         switchover_style_o <= route_reg[`CBIC_F_STYLE];
         if (!route_reg[`CBIC_F_SRC])
         begin
            div_a_source_o <= cbic_src_t'(ref_select_pin_i);
            div_b_source_o <= cbic_src_t'(ref_select_pin_i);
         end
         else
         begin
            div_a_source_o <= cbic_src_t'(route_reg[`CBIC_F_CODE_LO]);
            div_b_source_o <= cbic_src_t'(route_reg[`CBIC_F_CODE_HI]);
         end
      end
   end

   // align pulse on the falling edge of hold so both dividers restart together
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         divider_hold_o <= 1'b0;
         divider_align_o <= 1'b0;
      end
      else
      begin
         divider_hold_o <= route_reg[`CBIC_F_HOLD];
         divider_align_o <= divider_hold_o & ~route_reg[`CBIC_F_HOLD];
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         bank_a_supply_hint_o <= 1'b0;
         bank_b_supply_hint_o <= 1'b0;
         bank_a_quiet_disable_o <= 1'b0;
         bank_b_quiet_disable_o <= 1'b0;
         bank_a_power_off_o <= 1'b0;
         bank_b_power_off_o <= 1'b0;
         divider_a_power_off_o <= 1'b0;
         divider_b_power_off_o <= 1'b0;
      end
      else
      begin
         bank_a_supply_hint_o <= bank_reg[`CBIC_F_SUP_A];
         bank_b_supply_hint_o <= bank_reg[`CBIC_F_SUP_B];
         bank_a_quiet_disable_o <= bank_reg[`CBIC_F_QD_A];
         bank_b_quiet_disable_o <= bank_reg[`CBIC_F_QD_B];
         bank_a_power_off_o <= bank_reg[`CBIC_F_PWR_A];
         bank_b_power_off_o <= bank_reg[`CBIC_F_PWR_B];
         divider_a_power_off_o <= bank_reg[`CBIC_F_DIV_A];
         divider_b_power_off_o <= bank_reg[`CBIC_F_DIV_B];
      end
   end
endmodule
`default_nettype wire

//--- logic/cbic_i2c_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbic_params.svh"
module cbic_i2c_controller (
   // system
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // avalon-mm slave
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // serial link
   cbic_i2c_if.controller link
);
   import cbic_pkg::*;

   cbic_bit_state_t bstate;
   cbic_stage_t stage;
   logic [31:0] cfg;
   logic [31:0] tx_word;
   logic [31:0] rx_word;
   logic busy;
   logic nack;
   logic [1:0] q;
   logic [6:0] qcnt;
   logic [3:0] bit_n;
   logic [7:0] tx_sh;
   logic [7:0] rx_sh;
   logic [2:0] remain;
   logic [1:0] idx;
   logic ack_bit;
   logic scl_oe;
   logic sda_oe;
   logic wr_ok;
   logic go;
   logic tick;
   logic byte_end;
   logic set_nack;
   logic [31:0] be_mask;

   assign link.ctrl_scl_o = 1'b0;
   assign link.ctrl_sda_o = 1'b0;
   assign link.ctrl_scl_oe = scl_oe;
   assign link.ctrl_sda_oe = sda_oe;

   assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                     {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
   assign wr_ok = avs_write_i && !avs_waitrequest_o;
   assign go = wr_ok && avs_address_i == `CBIC_AV_CTRL && avs_byteenable_i[0]
               && avs_writedata_i[`CBIC_C_GO] && !busy;
   assign tick = busy && qcnt == 7'h00;
   assign byte_end = tick && bstate == M_BIT && q == 2'h3 && bit_n == 4'h8;
   assign set_nack = byte_end && stage != B_RDATA && ack_bit;

   function automatic logic [7:0] tx_byte(input cbic_stage_t st, input logic [1:0] ix);
      case (st)
         B_ADDRW: tx_byte = {`CBIC_ADDR_STEM, cfg[`CBIC_C_ABIT], 1'b0};
         B_ADDRR: tx_byte = {`CBIC_ADDR_STEM, cfg[`CBIC_C_ABIT], 1'b1};
         B_PTR: tx_byte = cfg[`CBIC_C_PTR +: 8];
         default: tx_byte = tx_word[{ix, 3'h0} +: 8];
      endcase
   endfunction

   // one wait cycle, then a single cycle with waitrequest low
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h0000_0000;
      end
      else if ((avs_read_i || avs_write_i) && avs_waitrequest_o)
      begin
         avs_waitrequest_o <= 1'b0;
         case (avs_address_i)
            `CBIC_AV_CTRL: avs_readdata_o <= cfg;
            `CBIC_AV_STAT: avs_readdata_o <= {30'h0, nack, busy};
            `CBIC_AV_TX: avs_readdata_o <= tx_word;
            `CBIC_AV_RX: avs_readdata_o <= rx_word;
            default: avs_readdata_o <= 32'h0000_0000;
         endcase
      end
      else
         avs_waitrequest_o <= 1'b1;
   end

   // setup held steady while a transfer runs
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         cfg <= 32'h0000_0000;
         tx_word <= 32'h0000_0000;
      end
      else if (wr_ok && !busy)
      begin
         if (avs_address_i == `CBIC_AV_CTRL)
            cfg <= ((cfg & ~be_mask) | (avs_writedata_i & be_mask)) & 32'hFFFF_FFFE;
         if (avs_address_i == `CBIC_AV_TX)
            tx_word <= (tx_word & ~be_mask) | (avs_writedata_i & be_mask);
      end
   end

   // set wins over a write-one clear in the same cycle
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         nack <= 1'b0;
      else if (set_nack)
         nack <= 1'b1;
      else if (wr_ok && avs_address_i == `CBIC_AV_STAT && avs_byteenable_i[0]
               && avs_writedata_i[`CBIC_S_NACK])
         nack <= 1'b0;
   end

   // quarter-bit divider
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         qcnt <= 7'h00;
      else if (!busy || qcnt == 7'h00)
         qcnt <= cfg[`CBIC_C_FAST] ? 7'(`CBIC_FAST_QCYC - 1) : 7'(`CBIC_STD_QCYC - 1);
      else
         qcnt <= qcnt - 7'h01;
   end

   // bus sequencer
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         bstate <= M_IDLE;
         stage <= B_ADDRW;
         busy <= 1'b0;
         q <= 2'h0;
         bit_n <= 4'h0;
         tx_sh <= 8'h00;
         rx_sh <= 8'h00;
         rx_word <= 32'h0000_0000;
         remain <= 3'h0;
         idx <= 2'h0;
         ack_bit <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
      end
      else if (go)
      begin
         busy <= 1'b1;
         bstate <= M_START;
         q <= 2'h0;
         idx <= 2'h0;
         // a write always sends the pointer; a read may skip it
         stage <= (avs_writedata_i[`CBIC_C_RD] && !avs_writedata_i[`CBIC_C_PTR_EN])
                  ? B_ADDRR : B_ADDRW;
         remain <= (avs_writedata_i[`CBIC_C_RD] && avs_writedata_i[`CBIC_C_CNT +: 3] == 3'h0)
                   ? 3'h1 : avs_writedata_i[`CBIC_C_CNT +: 3];
      end
      else if (tick)
      begin
         q <= q + 2'h1;
         case (bstate)
            M_START:
               case (q)
                  2'h0: sda_oe <= 1'b0;
                  2'h1: scl_oe <= 1'b0;
                  2'h2: sda_oe <= 1'b1;
                  default:
                  begin
                     scl_oe <= 1'b1;
                     bstate <= M_BIT;
                     bit_n <= 4'h0;
                     tx_sh <= tx_byte(stage, idx);
                  end
               endcase
            M_BIT:
               case (q)
                  2'h0:
                     if (bit_n != 4'h8)
                        sda_oe <= (stage == B_RDATA) ? 1'b0 : ~tx_sh[7];
                     else
                        sda_oe <= (stage == B_RDATA) && remain != 3'h1;
                  2'h1: scl_oe <= 1'b0;
                  2'h2:
                     if (bit_n != 4'h8)
                     begin
                        tx_sh <= {tx_sh[6:0], 1'b0};
                        rx_sh <= {rx_sh[6:0], link.sda};
                     end
                     else
                        ack_bit <= link.sda;
                  default:
                  begin
                     scl_oe <= 1'b1;
                     bit_n <= bit_n + 4'h1;
                     if (bit_n == 4'h8)
                     begin
                        bit_n <= 4'h0;
                        if (set_nack)
                           bstate <= M_STOP;
                        else
                           case (stage)
                              B_ADDRW:
                              begin
                                 stage <= B_PTR;
                                 tx_sh <= tx_byte(B_PTR, idx);
                              end
                              B_PTR:
                                 if (cfg[`CBIC_C_RD])
                                 begin
                                    stage <= B_ADDRR;
                                    bstate <= M_START;
                                 end
                                 else if (remain == 3'h0)
                                    bstate <= M_STOP;
                                 else
                                 begin
                                    stage <= B_DATA;
                                    tx_sh <= tx_byte(B_DATA, idx);
                                 end
                              B_DATA:
                              begin
                                 idx <= idx + 2'h1;
                                 remain <= remain - 3'h1;
                                 tx_sh <= tx_byte(B_DATA, idx + 2'h1);
                                 if (remain == 3'h1)
                                    bstate <= M_STOP;
                              end
                              B_ADDRR:
                                 stage <= B_RDATA;
                              default:
                              begin
                                 rx_word[{idx, 3'h0} +: 8] <= rx_sh;
                                 idx <= idx + 2'h1;
                                 remain <= remain - 3'h1;
                                 if (remain == 3'h1)
                                    bstate <= M_STOP;
                              end
                           endcase
                     end
                  end
               endcase
            M_STOP:
               case (q)
                  2'h0: sda_oe <= 1'b1;
                  2'h1: scl_oe <= 1'b0;
                  2'h2: sda_oe <= 1'b0;
                  default:
                  begin
                     busy <= 1'b0;
                     bstate <= M_IDLE;
                  end
               endcase
            default:
               busy <= 1'b0;
         endcase
      end
   end
endmodule
`default_nettype wire

//--- tb/cbic_link_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cbic_link_chk (
   // system
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // link
   input wire logic ctrl_scl_oe,
   input wire logic ctrl_sda_oe,
   input wire logic dev_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   // device turns sda round on the clock right after it sees scl fall
   a_dev_turn_fast: assert property ($changed(dev_sda_oe) |-> $past(scl, 2))
      else $error("device answered late after scl fall");
   a_scl_high_min: assert property ($rose(scl) |-> scl[*8])
      else $error("scl high phase too short");
   a_scl_low_min: assert property ($fell(scl) |-> (!scl)[*8])
      else $error("scl low phase too short");
   a_dev_hold_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("device moved sda while scl high");
   a_dev_move_low: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl))
      else $error("device moved sda too early");
   a_setup_rise: assert property ($rose(scl) |-> $stable(sda))
      else $error("sda changed at scl rise");
   a_start_quiet: assert property (scl && $fell(sda) |-> !dev_sda_oe)
      else $error("device driving at start");
   a_stop_quiet: assert property (scl && $rose(sda) |=> (!dev_sda_oe)[*8])
      else $error("device driving after stop");
   a_reset_idle: assert property ($fell(sys_rst_i) |->
                                  !(dev_sda_oe | ctrl_sda_oe | ctrl_scl_oe))
      else $error("link not idle after reset");
endmodule
`default_nettype wire

//--- tb/clock_buffer_i2c_control_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbic_params.svh"
module clock_buffer_i2c_control_regs_test;
   import cbic_pkg::*;
   logic sys_clk_i, sys_rst_i, abit, rsel, av_rd, av_wr, wait_o, sty, hold, align;
   logic [3:0] av_a, av_be;
   logic [31:0] av_wd, av_q, rd;
   wire logic [7:0] bank;
   cbic_src_t src_a, src_b;
   int err_count, checks, cyc, align_n;
   wire logic [11:0] obs = {sty, src_a, src_b, hold, bank};
   cbic_i2c_if lnk ();
   cbic_i2c_controller i_cbic_i2c_controller (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .avs_address_i(av_a), .avs_read_i(av_rd), .avs_write_i(av_wr), .avs_writedata_i(av_wd),
      .avs_byteenable_i(av_be), .avs_readdata_o(av_q), .avs_waitrequest_o(wait_o),
      .link(lnk.controller));
   cbic_i2c_device i_cbic_i2c_device (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .link(lnk.device), .addr_bit_chipsel_pin_i(abit), .ref_select_pin_i(rsel),
      .div_a_source_o(src_a), .div_b_source_o(src_b), .switchover_style_o(sty),
      .divider_hold_o(hold), .divider_align_o(align), .bank_a_supply_hint_o(bank[7]),
      .bank_b_supply_hint_o(bank[6]), .bank_a_quiet_disable_o(bank[5]),
      .bank_b_quiet_disable_o(bank[4]), .bank_a_power_off_o(bank[3]),
      .bank_b_power_off_o(bank[2]), .divider_a_power_off_o(bank[1]),
      .divider_b_power_off_o(bank[0]));
   cbic_link_chk i_cbic_link_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .ctrl_scl_oe(lnk.ctrl_scl_oe), .ctrl_sda_oe(lnk.ctrl_sda_oe),
      .dev_sda_oe(lnk.dev_sda_oe), .scl(lnk.scl), .sda(lnk.sda));
   task give_verdict;
      $display("Mismatches %0d, comparisons %0d", err_count, checks);
      if (err_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task dchk(input logic [11:0] e);
      chk({20'h0, obs}, {20'h0, e});
   endtask
   // one access; holds the request until waitrequest is seen low
   task av(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      av_wr <= w;
      av_rd <= !w;
      av_a <= a;
      av_wd <= d;
      do @(posedge sys_clk_i); while (wait_o !== 1'b0);
      rd = av_q;
      av_wr <= 1'b0;
      av_rd <= 1'b0;
   endtask
   function automatic logic [31:0] cw(logic r, logic p, logic f, logic b, logic [2:0] n,
                                      logic [7:0] ptr);
      return {8'h00, ptr, 5'h00, n, 3'h0, b, f, p, r, 1'b0};
   endfunction
   // ends with the final status word in rd
   task xfer(input logic [31:0] c, input logic [31:0] tx);
      av(1'b1, `CBIC_AV_TX, tx);
      av(1'b1, `CBIC_AV_CTRL, c | 32'h1);
      do av(1'b0, `CBIC_AV_STAT, 32'h0); while (rd[0] !== 1'b0);
   endtask
   initial
   begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (align === 1'b1)
         align_n++;
      if (cyc == 90000)
      begin
         err_count++;
         give_verdict();
      end
   end
   initial
   begin
      // reset high from time zero, all requests idle, every lane enabled
      {sys_rst_i, abit, rsel, av_rd, av_wr, av_a, av_wd, av_be} = {5'h10, 36'h0, 4'hF};
      repeat (2) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge sys_clk_i);
      dchk(12'h000);
      av(1'b0, 4'h2, 32'h0);
      chk(rd, 32'h0);
      xfer(cw(0, 0, 1, 0, 2, 0), 32'h0000_A5B1);
      dchk(12'hDA5);
      for (int c = 0; c < 4; c++)
      begin
         xfer(cw(0, 0, 1, 0, 1, 0), {25'h0, c[1:0], 5'h10});
         dchk({1'b0, c[0], c[1], 1'b0, 8'hA5});
      end
      chk(align_n, 1);
      rsel <= 1'b1;
      xfer(cw(0, 0, 1, 0, 1, 0), 32'h0);
      dchk(12'h6A5);
      xfer(cw(0, 0, 1, 0, 3, 1), 32'h0000_5A0F);
      dchk(12'h60F);
      xfer(cw(1, 1, 1, 0, 1, 1), 32'h0);
      av(1'b0, `CBIC_AV_RX, 32'h0);
      chk(rd[7:0], 8'h0F);
      xfer(cw(1, 0, 1, 0, 2, 0), 32'h0);
      av(1'b0, `CBIC_AV_RX, 32'h0);
      chk(rd[15:0], 16'h005A);
      // pointer-only write, then a one-byte current read from it
      xfer(cw(0, 0, 1, 0, 0, 1), 32'h0);
      xfer(cw(1, 0, 1, 0, 0, 0), 32'h0);
      av(1'b0, `CBIC_AV_RX, 32'h0);
      chk(rd[7:0], 8'h0F);
      xfer(cw(0, 0, 1, 1, 1, 1), 32'hFF);
      chk(rd[1:0], 2'b10);
      dchk(12'h60F);
      av(1'b1, `CBIC_AV_STAT, 32'h2);
      abit <= 1'b1;
      // quiet disable set in the same write that powers both banks back up
      xfer(cw(0, 0, 0, 1, 1, 1), 32'h30);
      chk(rd[1:0], 2'b00);
      dchk(12'h630);
      give_verdict();
   end
endmodule
`default_nettype wire
